/* File: rtl/cad_pkg.sv */
// constants for the complex add datapath
package cad_pkg;
    // data widths
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int SHIFT_W = 5;
    localparam int ADDR_W = 8;
    localparam int OPCODE_W = 16;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_VREG2 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_VREG3 = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_VREG4 = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_VREG5 = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_VREG6 = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_VREG7 = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_INSTR = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'h20;

    // status word field positions
    localparam int ST_RSHIFT_LSB = 0;
    localparam int ST_LSHIFT_LSB = 5;
    localparam int ST_ROUND_BIT = 10;
    localparam int ST_SAT_BIT = 11;
    localparam int ST_OVF_REAL_BIT = 12;
    localparam int ST_OVF_IMAG_BIT = 13;

    // clear register bit positions
    localparam int CLR_REAL_BIT = 0;
    localparam int CLR_IMAG_BIT = 1;

    // instruction words
    localparam logic [OPCODE_W-1:0] OP_ADD_FULL = 16'hE52A;
    localparam logic [OPCODE_W-1:0] OP_ADD_MIXED = 16'hE504;

    // reset values
    localparam logic [DATA_W-1:0] VREG_RESET = 32'h0000_0000;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 5'h00;
    localparam logic [OPCODE_W-1:0] OPCODE_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

/* File: rtl/cad_lane.sv */
// one real or imaginary lane: shift, round, add, saturate, overflow detect
`timescale 1ns/1ps
`default_nettype none
module cad_lane #(
    parameter int DW = 32,
    parameter int HW = 16,
    parameter int SW = 5
) (
    // mode and status controls
    input wire logic mixed_in,
    input wire logic round_in,
    input wire logic sat_in,
    input wire logic [SW-1:0] rshift_in,
    input wire logic [SW-1:0] lshift_in,
    // operands
    input wire logic [DW-1:0] base_in,
    input wire logic [DW-1:0] shifted_in,
    input wire logic [HW-1:0] half_in,
    // results
    output logic [DW-1:0] result_out,
    output logic ovf_out
);
    logic signed [DW-1:0] half_ext;
    logic signed [DW-1:0] pre;
    logic signed [DW:0] rnd_add;
    logic signed [DW:0] rs;
    logic signed [DW+1:0] sum;
    logic signed [DW+1:0] max_full;
    logic signed [DW+1:0] min_full;
    logic signed [DW:0] max_half;
    logic signed [DW:0] min_half;

    always_comb begin
        max_full = (DW+2)'((64'sd1 <<< (DW-1)) - 64'sd1);
        min_full = -(DW+2)'(64'sd1 <<< (DW-1));
        max_half = (DW+1)'((64'sd1 <<< (HW-1)) - 64'sd1);
        min_half = -(DW+1)'(64'sd1 <<< (HW-1));
        // mixed mode widens the half operand, scales it, adds in a 32-bit intermediate
        half_ext = DW'($signed(half_in));
        pre = mixed_in ? ((half_ext <<< lshift_in) + $signed(base_in)) : $signed(shifted_in);
        // half-unit add then floor so exact halves move upward
        rnd_add = '0;
        if (round_in && (rshift_in != '0)) begin
            rnd_add = (DW+1)'(1) <<< (rshift_in - SW'(1));
        end
        rs = ((DW+1)'(pre) + rnd_add) >>> rshift_in;
        sum = (DW+2)'($signed(base_in)) + (DW+2)'(rs);
        ovf_out = 1'b0;
        result_out = '0;
        if (mixed_in) begin
            ovf_out = (rs > max_half) || (rs < min_half);
            if (sat_in && (rs > max_half)) begin
                result_out = DW'(max_half[HW-1:0]);
            end else if (sat_in && (rs < min_half)) begin
                result_out = DW'(min_half[HW-1:0]);
            end else begin
                result_out = DW'(rs[HW-1:0]);
            end
        end else begin
            ovf_out = (sum > max_full) || (sum < min_full);
            if (sat_in && (sum > max_full)) begin
                result_out = max_full[DW-1:0];
            end else if (sat_in && (sum < min_full)) begin
                result_out = min_full[DW-1:0];
            end else begin
                result_out = sum[DW-1:0];
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/cad_top.sv */
// complex add datapath: vector registers, status word and two complex add instructions
//
// Overview of operation
// - instruction word E52A is the full-width add on registers seven/six and five/four
// - seven += shifted five, six += shifted four, sums written to seven and six
// - second full-width operand is shifted right by the right-shift amount first
// - round-select one rounds shifted-out bits, zero truncates them, both instructions
// - saturate-select one clamps full-width results to signed 32-bit range
// - real overflow flag set when the register seven result overflows
// - imaginary overflow flag set when the register six result overflows
// - each instruction completes in one cycle, no added wait
// - instruction word E504 is the mixed add reading four, three, two, writing five
// - mixed first operand: real in upper half of four, imaginary in lower half
// - mixed second operand: real from register three, imaginary from register two
// - sign-extend each 16-bit part to 32 bits, shift left by left-shift amount
// - mixed intermediate sum shifted right by right-shift amount, then rounded or truncated
// - saturate-select clamps mixed results to signed 16 bits, else keep low 16 bits
// - mixed real result to upper half of five, imaginary to lower half
// - real overflow flag set when mixed real part exceeds 16-bit range
// - imaginary overflow flag set when mixed imaginary part exceeds 16-bit range
// - rounding adds half a unit then floors, halves go toward positive infinity
`timescale 1ns/1ps
`default_nettype none
module cad_top #(
    parameter int DW = cad_pkg::DATA_W,
    parameter int HW = cad_pkg::HALF_W,
    parameter int SW = cad_pkg::SHIFT_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [cad_pkg::ADDR_W-1:0] addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [DW-1:0] rd_data_out,
    // status
    output logic real_overflow_flag_out,
    output logic imag_overflow_flag_out,
    output logic exec_done_out
);
    typedef struct packed {
        logic [DW-1:0] vector_reg_two;
        logic [DW-1:0] vector_reg_three;
        logic [DW-1:0] vector_reg_four;
        logic [DW-1:0] vector_reg_five;
        logic [DW-1:0] vector_reg_six;
        logic [DW-1:0] vector_reg_seven;
        logic [SW-1:0] right_shift_amount;
        logic [SW-1:0] left_shift_amount;
        logic round_select;
        logic saturate_select;
        logic real_overflow_flag;
        logic imag_overflow_flag;
        logic [cad_pkg::OPCODE_W-1:0] last_opcode;
        logic exec_done;
        logic [DW-1:0] rd_data;
    } cad_state_t;

    cad_state_t state_ff;
    cad_state_t nxt_state;

    logic is_full;
    logic is_mixed;
    logic mixed_sel;
    logic [DW-1:0] real_base;
    logic [DW-1:0] imag_base;
    logic [DW-1:0] real_res;
    logic [DW-1:0] imag_res;
    logic real_ovf;
    logic imag_ovf;
    logic [DW-1:0] status_word;
    logic [cad_pkg::OPCODE_W-1:0] op_word;

    // instruction decode from a write to the instruction register
    assign op_word = wr_data_in[cad_pkg::OPCODE_W-1:0];
    assign is_full = wr_en_in && (addr_in == cad_pkg::ADDR_INSTR)
        && (op_word == cad_pkg::OP_ADD_FULL);
    assign is_mixed = wr_en_in && (addr_in == cad_pkg::ADDR_INSTR)
        && (op_word == cad_pkg::OP_ADD_MIXED);
    assign mixed_sel = (op_word == cad_pkg::OP_ADD_MIXED);

    // operand steering shared by both instructions
    assign real_base = mixed_sel ? state_ff.vector_reg_three : state_ff.vector_reg_seven;
    assign imag_base = mixed_sel ? state_ff.vector_reg_two : state_ff.vector_reg_six;

    cad_lane #(
        .DW(DW),
        .HW(HW),
        .SW(SW)
    ) u_real_lane (
        .mixed_in(mixed_sel),
        .round_in(state_ff.round_select),
        .sat_in(state_ff.saturate_select),
        .rshift_in(state_ff.right_shift_amount),
        .lshift_in(state_ff.left_shift_amount),
        .base_in(real_base),
        .shifted_in(state_ff.vector_reg_five),
        .half_in(state_ff.vector_reg_four[DW-1:HW]),
        .result_out(real_res),
        .ovf_out(real_ovf)
    );

    cad_lane #(
        .DW(DW),
        .HW(HW),
        .SW(SW)
    ) u_imag_lane (
        .mixed_in(mixed_sel),
        .round_in(state_ff.round_select),
        .sat_in(state_ff.saturate_select),
        .rshift_in(state_ff.right_shift_amount),
        .lshift_in(state_ff.left_shift_amount),
        .base_in(imag_base),
        .shifted_in(state_ff.vector_reg_four),
        .half_in(state_ff.vector_reg_four[HW-1:0]),
        .result_out(imag_res),
        .ovf_out(imag_ovf)
    );

    // status word as software sees it
    always_comb begin
        status_word = '0;
        status_word[cad_pkg::ST_RSHIFT_LSB +: SW] = state_ff.right_shift_amount;
        status_word[cad_pkg::ST_LSHIFT_LSB +: SW] = state_ff.left_shift_amount;
        status_word[cad_pkg::ST_ROUND_BIT] = state_ff.round_select;
        status_word[cad_pkg::ST_SAT_BIT] = state_ff.saturate_select;
        status_word[cad_pkg::ST_OVF_REAL_BIT] = state_ff.real_overflow_flag;
        status_word[cad_pkg::ST_OVF_IMAG_BIT] = state_ff.imag_overflow_flag;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.exec_done = 1'b0;
        nxt_state.rd_data = cad_pkg::READ_ZERO;
        if (wr_en_in) begin
            case (addr_in)
                cad_pkg::ADDR_VREG2: begin
                    nxt_state.vector_reg_two = wr_data_in;
                end
                cad_pkg::ADDR_VREG3: begin
                    nxt_state.vector_reg_three = wr_data_in;
                end
                cad_pkg::ADDR_VREG4: begin
                    nxt_state.vector_reg_four = wr_data_in;
                end
                cad_pkg::ADDR_VREG5: begin
                    nxt_state.vector_reg_five = wr_data_in;
                end
                cad_pkg::ADDR_VREG6: begin
                    nxt_state.vector_reg_six = wr_data_in;
                end
                cad_pkg::ADDR_VREG7: begin
                    nxt_state.vector_reg_seven = wr_data_in;
                end
                cad_pkg::ADDR_STATUS: begin
                    // flag bits are read-only here
                    nxt_state.right_shift_amount = wr_data_in[cad_pkg::ST_RSHIFT_LSB +: SW];
                    nxt_state.left_shift_amount = wr_data_in[cad_pkg::ST_LSHIFT_LSB +: SW];
                    nxt_state.round_select = wr_data_in[cad_pkg::ST_ROUND_BIT];
                    nxt_state.saturate_select = wr_data_in[cad_pkg::ST_SAT_BIT];
                end
                cad_pkg::ADDR_INSTR: begin
                    nxt_state.last_opcode = op_word;
                end
                cad_pkg::ADDR_CLEAR: begin
                    if (wr_data_in[cad_pkg::CLR_REAL_BIT]) begin
                        nxt_state.real_overflow_flag = 1'b0;
                    end
                    if (wr_data_in[cad_pkg::CLR_IMAG_BIT]) begin
                        nxt_state.imag_overflow_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // results land at the same edge that takes the instruction
        if (is_full) begin
            nxt_state.vector_reg_seven = real_res;
            nxt_state.vector_reg_six = imag_res;
            nxt_state.exec_done = 1'b1;
        end
        if (is_mixed) begin
            nxt_state.vector_reg_five = {real_res[HW-1:0], imag_res[HW-1:0]};
            nxt_state.exec_done = 1'b1;
        end
        // flags only ever set by the instructions; set wins over a clear
        if ((is_full || is_mixed) && real_ovf) begin
            nxt_state.real_overflow_flag = 1'b1;
        end
        if ((is_full || is_mixed) && imag_ovf) begin
            nxt_state.imag_overflow_flag = 1'b1;
        end
        if (rd_en_in) begin
            case (addr_in)
                cad_pkg::ADDR_VREG2: nxt_state.rd_data = state_ff.vector_reg_two;
                cad_pkg::ADDR_VREG3: nxt_state.rd_data = state_ff.vector_reg_three;
                cad_pkg::ADDR_VREG4: nxt_state.rd_data = state_ff.vector_reg_four;
                cad_pkg::ADDR_VREG5: nxt_state.rd_data = state_ff.vector_reg_five;
                cad_pkg::ADDR_VREG6: nxt_state.rd_data = state_ff.vector_reg_six;
                cad_pkg::ADDR_VREG7: nxt_state.rd_data = state_ff.vector_reg_seven;
                cad_pkg::ADDR_STATUS: nxt_state.rd_data = status_word;
                cad_pkg::ADDR_INSTR: nxt_state.rd_data = DW'(state_ff.last_opcode);
                default: nxt_state.rd_data = cad_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff.vector_reg_two <= cad_pkg::VREG_RESET;
            state_ff.vector_reg_three <= cad_pkg::VREG_RESET;
            state_ff.vector_reg_four <= cad_pkg::VREG_RESET;
            state_ff.vector_reg_five <= cad_pkg::VREG_RESET;
            state_ff.vector_reg_six <= cad_pkg::VREG_RESET;
            state_ff.vector_reg_seven <= cad_pkg::VREG_RESET;
            state_ff.right_shift_amount <= cad_pkg::SHIFT_RESET;
            state_ff.left_shift_amount <= cad_pkg::SHIFT_RESET;
            state_ff.round_select <= 1'b0;
            state_ff.saturate_select <= 1'b0;
            state_ff.real_overflow_flag <= 1'b0;
            state_ff.imag_overflow_flag <= 1'b0;
            state_ff.last_opcode <= cad_pkg::OPCODE_RESET;
            state_ff.exec_done <= 1'b0;
            state_ff.rd_data <= cad_pkg::READ_ZERO;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rd_data_out = state_ff.rd_data;
    assign real_overflow_flag_out = state_ff.real_overflow_flag;
    assign imag_overflow_flag_out = state_ff.imag_overflow_flag;
    assign exec_done_out = state_ff.exec_done;
endmodule
`default_nettype wire

/* File: bench/cad_top_asserts.sv */
// assertion checker for the complex add datapath ports
`timescale 1ns/1ps
`default_nettype none
module cad_top_asserts #(
    parameter int DW = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [cad_pkg::ADDR_W-1:0] addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [DW-1:0] rd_data_out,
    // status
    input wire logic real_overflow_flag_out,
    input wire logic imag_overflow_flag_out,
    input wire logic exec_done_out
);
    logic cmd_ok;
    logic clr_r;
    logic clr_i;
    logic [DW-1:0] wd_d1;
    logic [DW-1:0] wd_d2;
    assign cmd_ok = wr_en_in && addr_in == cad_pkg::ADDR_INSTR &&
        (wr_data_in[15:0] == cad_pkg::OP_ADD_FULL || wr_data_in[15:0] == cad_pkg::OP_ADD_MIXED);
    assign clr_r = wr_en_in && addr_in == cad_pkg::ADDR_CLEAR && wr_data_in[0];
    assign clr_i = wr_en_in && addr_in == cad_pkg::ADDR_CLEAR && wr_data_in[1];
    always_ff @(posedge clk_in) begin
        wd_d1 <= wr_data_in;
        wd_d2 <= wd_d1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_instr(logic [15:0] op);
        wr_en_in && addr_in == cad_pkg::ADDR_INSTR && wr_data_in[15:0] == op;
    endsequence
    sequence s_wr_status;
        wr_en_in && addr_in == cad_pkg::ADDR_STATUS;
    endsequence
    sequence s_rd_status;
        rd_en_in && addr_in == cad_pkg::ADDR_STATUS;
    endsequence
    a_done_full: assert property (s_instr(cad_pkg::OP_ADD_FULL) |=> exec_done_out)
        else $error("full add not acknowledged");
    a_done_mixed: assert property (s_instr(cad_pkg::OP_ADD_MIXED) |=> exec_done_out)
        else $error("mixed add not acknowledged");
    a_done_cause: assert property (exec_done_out |-> $past(cmd_ok))
        else $error("done without a valid instruction");
    a_real_sticky: assert property (real_overflow_flag_out && !clr_r |=> real_overflow_flag_out)
        else $error("real flag dropped without clear");
    a_imag_sticky: assert property (imag_overflow_flag_out && !clr_i |=> imag_overflow_flag_out)
        else $error("imag flag dropped without clear");
    a_real_clear: assert property (clr_r && !cmd_ok |=> !real_overflow_flag_out)
        else $error("real flag not cleared");
    a_imag_clear: assert property (clr_i && !cmd_ok |=> !imag_overflow_flag_out)
        else $error("imag flag not cleared");
    a_rd_idle: assert property (!rd_en_in |=> rd_data_out == '0)
        else $error("read data not zero outside a read");
    a_flag_cause: assert property ($rose(real_overflow_flag_out) || $rose(imag_overflow_flag_out) |-> $past(cmd_ok))
        else $error("flag set without an instruction");
    a_status_flags: assert property (s_rd_status |=> rd_data_out[13:12] ==
        {$past(imag_overflow_flag_out), $past(real_overflow_flag_out)})
        else $error("status flag bits wrong");
    a_status_rw: assert property (s_wr_status ##1 s_rd_status |=> rd_data_out[11:0] == wd_d2[11:0])
        else $error("status fields not kept");
endmodule
bind cad_top cad_top_asserts #(.DW(DW)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .real_overflow_flag_out(real_overflow_flag_out), .imag_overflow_flag_out(imag_overflow_flag_out),
    .exec_done_out(exec_done_out));
`default_nettype wire

/* File: bench/cad_host_model.sv */
// host core model issuing register accesses and instructions
`timescale 1ns/1ps
`default_nettype none
module cad_host_model (
    // clock
    input wire logic clk_in,
    // register port, master side
    output logic [cad_pkg::ADDR_W-1:0] addr_out,
    output logic [31:0] wr_data_out,
    output logic wr_en_out,
    output logic rd_en_out,
    input wire logic [31:0] rd_data_in
);
    initial begin
        addr_out = 8'h00;
        wr_data_out = 32'h0000_0000;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
    end
    // keep leaves the strobe up so the next access follows with no gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic keep);
        addr_out <= a;
        wr_data_out <= d;
        wr_en_out <= 1'b1;
        @(posedge clk_in);
        if (!keep) begin
            wr_en_out <= 1'b0;
            wr_data_out <= ~d;
            @(posedge clk_in);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        wr_en_out <= 1'b0;
        addr_out <= a;
        rd_en_out <= 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        d = rd_data_in;
    endtask
endmodule
`default_nettype wire

/* File: bench/cad_top_tb_top.sv */
// self-checking testbench for the complex add datapath
`timescale 1ns/1ps
`default_nettype none
module cad_top_tb_top;
    logic clk_in;
    logic rst_n_in = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr_en;
    logic rd_en;
    logic ovf_r;
    logic ovf_i;
    logic done;
    logic [1:0] exp_fl = 2'b00;
    int n_fail = 0;
    int total_checks = 0;
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    cad_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rd_data_out(rdata), .real_overflow_flag_out(ovf_r),
        .imag_overflow_flag_out(ovf_i), .exec_done_out(done));
    cad_host_model host (.clk_in(clk_in), .addr_out(addr), .wr_data_out(wdata), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .rd_data_in(rdata));
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp, input string what);
        chk_word({30'h0, got}, {30'h0, exp}, what);
    endtask
    // returns {overflow, value}; w is the destination width
    function automatic logic [32:0] calc(logic signed [33:0] a, logic signed [33:0] b, int r, int w,
        logic rn, logic sa);
        logic signed [33:0] s;
        logic signed [33:0] mx;
        if (rn && r > 0) b = b + (34'sh1 <<< (r - 1));
        s = a + (b >>> r);
        mx = (34'sh1 <<< (w - 1)) - 34'sh1;
        if (s > mx) return {1'b1, sa ? mx[31:0] : s[31:0]};
        if (s < ~mx) return {1'b1, sa ? ~mx[31:0] : s[31:0]};
        return {1'b0, s[31:0]};
    endfunction
    // v holds registers two to seven
    task automatic run(input logic [15:0] op, input logic [11:0] st, input logic [31:0] v[6], input logic clr);
        logic [32:0] er;
        logic [32:0] ei;
        logic [31:0] t1;
        logic [31:0] t2;
        logic [31:0] got;
        foreach (v[i]) host.wr(cad_pkg::ADDR_VREG2 + 8'(4 * i), v[i], 1'b0);
        host.wr(cad_pkg::ADDR_STATUS, {20'h0, st}, 1'b0);
        if (clr) host.wr(cad_pkg::ADDR_CLEAR, 32'h3, 1'b0);
        host.wr(cad_pkg::ADDR_INSTR, {16'h0, op}, 1'b0);
        chk_bit({1'b0, done}, 2'b01, "done");
        if (op == cad_pkg::OP_ADD_FULL) begin
            er = calc($signed(v[5]), $signed(v[3]), int'(st[4:0]), 32, st[10], st[11]);
            ei = calc($signed(v[4]), $signed(v[2]), int'(st[4:0]), 32, st[10], st[11]);
            host.rd(cad_pkg::ADDR_VREG7, got);
            chk_word(got, er[31:0], "real32");
            host.rd(cad_pkg::ADDR_VREG6, got);
            chk_word(got, ei[31:0], "imag32");
        end else begin
            t1 = ({{16{v[2][31]}}, v[2][31:16]} << st[9:5]) + v[1];
            t2 = ({{16{v[2][15]}}, v[2][15:0]} << st[9:5]) + v[0];
            er = calc(34'sh0, $signed(t1), int'(st[4:0]), 16, st[10], st[11]);
            ei = calc(34'sh0, $signed(t2), int'(st[4:0]), 16, st[10], st[11]);
            host.rd(cad_pkg::ADDR_VREG5, got);
            chk_word(got, {er[15:0], ei[15:0]}, "mixed");
        end
        exp_fl = clr ? {er[32], ei[32]} : exp_fl | {er[32], ei[32]};
        chk_bit({ovf_r, ovf_i}, exp_fl, "flags");
    endtask
    task automatic t_regs;
        logic [31:0] got;
        host.rd(cad_pkg::ADDR_VREG5, got);
        chk_word(got, cad_pkg::VREG_RESET, "reset vreg5");
        host.rd(8'h40, got);
        chk_word(got, cad_pkg::READ_ZERO, "unmapped");
        host.wr(cad_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 1'b1);
        host.rd(cad_pkg::ADDR_STATUS, got);
        chk_word(got, 32'h0000_0FFF, "status");
        $display("t_regs done");
    endtask
    task automatic t_full;
        run(cad_pkg::OP_ADD_FULL, 12'h402, '{32'h0, 32'h0, 32'hFFFF_FFFA, 32'h6, 32'hA, 32'hA}, 1'b1);
        run(cad_pkg::OP_ADD_FULL, 12'h002, '{32'h0, 32'h0, 32'hFFFF_FFFA, 32'h6, 32'hA, 32'hA}, 1'b1);
        run(cad_pkg::OP_ADD_FULL, 12'h000, '{32'h0, 32'h0, 32'hFFFF_FFFF, 32'h1, 32'h8000_0000, 32'h7FFF_FFFF}, 1'b1);
        run(cad_pkg::OP_ADD_FULL, 12'h41F, '{32'h0, 32'h0, 32'h4000_0000, 32'h8000_0000, 32'h0, 32'h0}, 1'b1);
        $display("t_full done");
    endtask
    task automatic t_mixed;
        run(cad_pkg::OP_ADD_MIXED, 12'h000, '{32'hC, 32'hD, 32'h0004_0003, 32'h0, 32'h0, 32'h0}, 1'b1);
        run(cad_pkg::OP_ADD_MIXED, 12'h001, '{32'hC, 32'hD, 32'h0004_0003, 32'h0, 32'h0, 32'h0}, 1'b1);
        run(cad_pkg::OP_ADD_MIXED, 12'h401, '{32'hC, 32'hD, 32'h0004_0003, 32'h0, 32'h0, 32'h0}, 1'b1);
        run(cad_pkg::OP_ADD_MIXED, 12'h441, '{32'hFFFF_FFF7, 32'hD, 32'hFFFC_0003, 32'h0, 32'h0, 32'h0}, 1'b1);
        run(cad_pkg::OP_ADD_MIXED, 12'h800, '{32'hFFFF_FFFF, 32'h1, 32'h7FFF_8000, 32'h0, 32'h0, 32'h0}, 1'b1);
        run(cad_pkg::OP_ADD_MIXED, 12'h000, '{32'hFFFF_FFFF, 32'h1, 32'h7FFF_8000, 32'h0, 32'h0, 32'h0}, 1'b1);
        $display("t_mixed done");
    endtask
    task automatic t_sticky;
        logic [31:0] got;
        run(cad_pkg::OP_ADD_FULL, 12'h800, '{32'h0, 32'h0, 32'hFFFF_FFFF, 32'h1, 32'h8000_0000, 32'h7FFF_FFFF}, 1'b1);
        run(cad_pkg::OP_ADD_MIXED, 12'h000, '{32'hC, 32'hD, 32'h0004_0003, 32'h0, 32'h0, 32'h0}, 1'b0);
        host.wr(cad_pkg::ADDR_CLEAR, 32'h1, 1'b0);
        chk_bit({ovf_r, ovf_i}, 2'b01, "clear real");
        host.wr(cad_pkg::ADDR_INSTR, 32'h1234, 1'b0);
        chk_bit({1'b0, done}, 2'b00, "no done");
        host.rd(cad_pkg::ADDR_INSTR, got);
        chk_word(got, 32'h0000_1234, "last word");
        chk_bit({ovf_r, ovf_i}, 2'b01, "flags kept");
        host.wr(cad_pkg::ADDR_CLEAR, 32'h2, 1'b0);
        chk_bit({ovf_r, ovf_i}, 2'b00, "clear imag");
        $display("t_sticky done");
    endtask
    task automatic t_b2b;
        logic [31:0] got;
        run(cad_pkg::OP_ADD_FULL, 12'h000, '{32'h0, 32'h0, 32'h3, 32'h2, 32'h0, 32'h1}, 1'b1);
        host.wr(cad_pkg::ADDR_INSTR, {16'h0, cad_pkg::OP_ADD_FULL}, 1'b1);
        host.wr(cad_pkg::ADDR_INSTR, {16'h0, cad_pkg::OP_ADD_FULL}, 1'b0);
        host.rd(cad_pkg::ADDR_VREG7, got);
        chk_word(got, 32'h0000_0007, "chained");
        $display("t_b2b done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // tests take a few hundred cycles; allow ten thousand
    initial begin
        #1000000;
        n_fail++;
        $display("MISMATCH %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_full();
        t_mixed();
        t_sticky();
        t_b2b();
        print_verdict();
    end
endmodule
`default_nettype wire
